// [tcf_flag_cell.sv]
// One event flag with read-then-write-zero clearing.
// Assumes readDone and writeDone are one-cycle strobes of a finished bus access.
`default_nettype none

module tcf_flag_cell (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic setEvent,
  input  wire logic readDone,
  input  wire logic readBit,
  input  wire logic writeDone,
  input  wire logic writeBit,
  output var  logic flag_r
);

  logic armed_r;
  logic armed_nxt;
  logic clearNow;
  logic flag_nxt;

  // R13 clear after read
  assign clearNow  = writeDone && !writeBit && armed_r;
  // R17 set wins
  assign flag_nxt  = setEvent ? 1'b1 : (clearNow ? 1'b0 : flag_r);
  // R12 stale zero read
  assign armed_nxt = readDone ? readBit : (writeDone ? 1'b0 : armed_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r  <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      flag_r  <= flag_nxt;
      armed_r <= armed_nxt;
    end
  end

endmodule // tcf_flag_cell

`default_nettype wire

// [tcf_pkg.sv]
// Constants, field layouts and carrier types of the channel-0 event flag block.
// Assumes a 16-bit counter and an APB master on the same clock.
`default_nettype none

package tcf_pkg;

  localparam int ADDR_W   = 24;
  localparam int DATA_W   = 32;
  localparam int CNT_W    = 16;
  localparam int NUM_FLAG = 5;
  localparam int NUM_PIN  = 4;

  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_FLAGS    = 24'h0f0273;
  localparam logic [ADDR_W-1:0] IDX_MODE     = 24'h0f0300;
  localparam logic [ADDR_W-1:0] IDX_EDGE     = 24'h0f0301;
  localparam logic [ADDR_W-1:0] IDX_MATCH_A  = 24'h0f0302;
  localparam logic [ADDR_W-1:0] IDX_MATCH_B  = 24'h0f0303;
  localparam logic [ADDR_W-1:0] IDX_MATCH_C  = 24'h0f0304;
  localparam logic [ADDR_W-1:0] IDX_MATCH_D  = 24'h0f0305;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 24'h0f0306;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 24'h0f0307;
  localparam int                IDX_SHIFT    = 2;

  // Field positions inside the flag register and the mode register
  localparam int POS_WRAP = 4;
  localparam int POS_D    = 3;
  localparam int POS_C    = 2;
  localparam int POS_B    = 1;
  localparam int POS_A    = 0;
  localparam int POS_CAPTURE_MODE = 0;

  localparam logic [7:0]       REG8_RESET  = 8'h00;
  localparam logic [CNT_W-1:0] MATCH_RESET = 16'h0000;

  // Edge select codes, two bits per pin
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  typedef struct packed {
    logic wrap;
    logic d;
    logic c;
    logic b;
    logic a;
  } tcf_flags_t;

  typedef struct packed {
    logic [1:0] d;
    logic [1:0] c;
    logic [1:0] b;
    logic [1:0] a;
  } tcf_edge_t;

  typedef enum logic {
    TCF_IDLE,
    TCF_ANSWER
  } tcf_bus_state_t;

endpackage : tcf_pkg

`default_nettype wire

// [tcf_status_flags.sv]
// Channel-0 event flag register of a 16-bit timer with an APB slave.
// Assumes counterValue comes from logic on clk; capture pins are asynchronous.
//
// Notes on behaviour
// R01: Eight-bit flag register, reset zero, top bits zero
// R02: Wrap bit 4, flags D..A bits 3..0
// R03: Reset value undefined with clock gate off
// R04: Wrap flag set on counter max to zero
// R05: Wrap also set when match clears counter; the code sets wrap only on max to zero
// R06: Capture mode: pins A/B selected edge sets
// R07: Capture mode: pins C/D edge sets, buffers too
// R08: Compare mode: counter equals match A sets
// R09: Compare mode: counter equals match B sets
// R10: Compare mode: match C/D sets, buffers too
// R11: Writing one leaves flag unchanged
// R12: Zero after zero read leaves flag
// R13: Zero after one read clears flag
// R14: Software may disable interrupts, then clear
// R15: Software may clear with enabled flags zero
// R16: Software clears enabled and target together
// R17: Hardware set beats simultaneous clear
`default_nettype none

module tcf_status_flags
  import tcf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output var  logic [DATA_W-1:0] prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [CNT_W-1:0]  counterValue,
  input  wire logic [NUM_PIN-1:0] capturePin,
  output var  tcf_flags_t        eventFlags,
  output var  logic              irq
);

  tcf_bus_state_t state_r;
  tcf_bus_state_t state_nxt;

  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] prdata_nxt;
  logic              pready_r;
  logic              pslverr_r;
  logic              pslverr_nxt;

  logic              captureMode_r;
  tcf_edge_t         edgeSel_r;
  logic [CNT_W-1:0]  matchA_r;
  logic [CNT_W-1:0]  matchB_r;
  logic [CNT_W-1:0]  matchC_r;
  logic [CNT_W-1:0]  matchD_r;
  tcf_flags_t        irqStat_r;
  tcf_flags_t        irqStat_nxt;
  tcf_flags_t        irqMask_r;
  logic              irq_r;

  logic [CNT_W-1:0]  cntPrev_r;
  tcf_flags_t        flagState;
  tcf_flags_t        setVec;

  // Register word index from the byte address
  logic [ADDR_W-1:0] regIdx;
  logic              alignedOk;
  logic              selFlags;
  logic              selMode;
  logic              selEdge;
  logic              selMatchA;
  logic              selMatchB;
  logic              selMatchC;
  logic              selMatchD;
  logic              selIrqStat;
  logic              selIrqMask;
  logic              addrHit;
  logic              accessReq;
  logic              xferDone;
  logic              wrDone;
  logic              rdDone;
  logic              flagWrite;
  logic              flagRead;

  assign regIdx     = {{IDX_SHIFT{1'b0}}, paddr[ADDR_W-1:IDX_SHIFT]};
  assign alignedOk  = (paddr[IDX_SHIFT-1:0] == 2'h0);
  assign selFlags   = alignedOk && (regIdx == IDX_FLAGS);
  assign selMode    = alignedOk && (regIdx == IDX_MODE);
  assign selEdge    = alignedOk && (regIdx == IDX_EDGE);
  assign selMatchA  = alignedOk && (regIdx == IDX_MATCH_A);
  assign selMatchB  = alignedOk && (regIdx == IDX_MATCH_B);
  assign selMatchC  = alignedOk && (regIdx == IDX_MATCH_C);
  assign selMatchD  = alignedOk && (regIdx == IDX_MATCH_D);
  assign selIrqStat = alignedOk && (regIdx == IDX_IRQ_STAT);
  assign selIrqMask = alignedOk && (regIdx == IDX_IRQ_MASK);
  assign addrHit    = selFlags | selMode | selEdge | selMatchA | selMatchB
                    | selMatchC | selMatchD | selIrqStat | selIrqMask;

  // One wait state so every bus output comes from a flop
  assign accessReq = psel && penable;
  assign xferDone  = (state_r == TCF_ANSWER) && accessReq;
  assign wrDone    = xferDone && pwrite && addrHit;
  assign rdDone    = xferDone && !pwrite && addrHit;
  assign flagWrite = wrDone && selFlags;
  assign flagRead  = rdDone && selFlags;

  always_comb begin
    case (state_r)
      TCF_IDLE:   state_nxt = accessReq ? TCF_ANSWER : TCF_IDLE;
      TCF_ANSWER: state_nxt = TCF_IDLE;
      default:    state_nxt = TCF_IDLE;
    endcase
  end

  // Read multiplexer; narrow registers sit in the low bits
  logic [DATA_W-1:0] rdMux;
  logic [DATA_W-1:0] rdFlags;
  logic [DATA_W-1:0] rdMode;
  logic [DATA_W-1:0] rdEdge;
  logic [DATA_W-1:0] rdIrqStat;
  logic [DATA_W-1:0] rdIrqMask;

  // R01 top bits zero
  assign rdFlags   = {{(DATA_W-NUM_FLAG){1'b0}}, flagState};
  assign rdMode    = {{(DATA_W-1){1'b0}}, captureMode_r};
  assign rdEdge    = {{(DATA_W-8){1'b0}}, edgeSel_r};
  assign rdIrqStat = {{(DATA_W-NUM_FLAG){1'b0}}, irqStat_r};
  assign rdIrqMask = {{(DATA_W-NUM_FLAG){1'b0}}, irqMask_r};

  assign rdMux = selFlags   ? rdFlags :
                 selMode    ? rdMode :
                 selEdge    ? rdEdge :
                 selMatchA  ? {{(DATA_W-CNT_W){1'b0}}, matchA_r} :
                 selMatchB  ? {{(DATA_W-CNT_W){1'b0}}, matchB_r} :
                 selMatchC  ? {{(DATA_W-CNT_W){1'b0}}, matchC_r} :
                 selMatchD  ? {{(DATA_W-CNT_W){1'b0}}, matchD_r} :
                 selIrqStat ? rdIrqStat :
                 selIrqMask ? rdIrqMask : {DATA_W{1'b0}};

  assign prdata_nxt  = (state_r == TCF_IDLE && accessReq && !pwrite) ? rdMux : prdata_r;
  assign pslverr_nxt = (state_r == TCF_IDLE && accessReq) ? !addrHit : pslverr_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r   <= TCF_IDLE;
      pready_r  <= 1'b0;
      prdata_r  <= {DATA_W{1'b0}};
      pslverr_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      pready_r  <= (state_nxt == TCF_ANSWER);
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Control registers of the channel
  always_ff @(posedge clk) begin
    if (rst) begin
      captureMode_r <= 1'b0;
      edgeSel_r     <= REG8_RESET;
      irqMask_r     <= REG8_RESET[NUM_FLAG-1:0];
    end else if (wrDone) begin
      if (selMode)    captureMode_r <= pwdata[POS_CAPTURE_MODE];
      if (selEdge)    edgeSel_r     <= pwdata[7:0];
      if (selIrqMask) irqMask_r     <= pwdata[NUM_FLAG-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      matchA_r <= MATCH_RESET;
      matchB_r <= MATCH_RESET;
      matchC_r <= MATCH_RESET;
      matchD_r <= MATCH_RESET;
    end else if (wrDone) begin
      if (selMatchA) matchA_r <= pwdata[CNT_W-1:0];
      if (selMatchB) matchB_r <= pwdata[CNT_W-1:0];
      if (selMatchC) matchC_r <= pwdata[CNT_W-1:0];
      if (selMatchD) matchD_r <= pwdata[CNT_W-1:0];
    end
  end

  // Capture pins: three flops, a change counts once stages two and three agree
  logic [NUM_PIN-1:0] pinS1_r;
  logic [NUM_PIN-1:0] pinS2_r;
  logic [NUM_PIN-1:0] pinS3_r;
  logic [NUM_PIN-1:0] pinLevel_r;
  logic [NUM_PIN-1:0] pinRise;
  logic [NUM_PIN-1:0] pinFall;
  logic [NUM_PIN-1:0] pinEdgeHit;
  logic [1:0]         pinSel [NUM_PIN];

  assign pinSel[0] = edgeSel_r.a;
  assign pinSel[1] = edgeSel_r.b;
  assign pinSel[2] = edgeSel_r.c;
  assign pinSel[3] = edgeSel_r.d;

  always_ff @(posedge clk) begin
    if (rst) begin
      pinS1_r    <= {NUM_PIN{1'b0}};
      pinS2_r    <= {NUM_PIN{1'b0}};
      pinS3_r    <= {NUM_PIN{1'b0}};
      pinLevel_r <= {NUM_PIN{1'b0}};
    end else begin
      pinS1_r    <= capturePin;
      pinS2_r    <= pinS1_r;
      pinS3_r    <= pinS2_r;
      pinLevel_r <= (pinS2_r == pinS3_r) ? pinS3_r : pinLevel_r;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PIN; gp++) begin : g_pin
      assign pinRise[gp] = (pinS2_r[gp] == pinS3_r[gp]) && pinS3_r[gp] && !pinLevel_r[gp];
      assign pinFall[gp] = (pinS2_r[gp] == pinS3_r[gp]) && !pinS3_r[gp] && pinLevel_r[gp];
      // Code 11 is a prohibited setting and captures nothing
      assign pinEdgeHit[gp] = ((pinSel[gp] == EDGE_RISE) && pinRise[gp])
                            | ((pinSel[gp] == EDGE_FALL) && pinFall[gp])
                            | ((pinSel[gp] == EDGE_BOTH) && (pinRise[gp] | pinFall[gp]));
    end
  endgenerate

  // Counter watch; a match counts once per arrival, not every idle cycle
  logic cntMoved;
  logic cntWrap;
  logic eqA;
  logic eqB;
  logic eqC;
  logic eqD;

  always_ff @(posedge clk) begin
    if (rst) begin
      cntPrev_r <= CNT_ZERO;
    end else begin
      cntPrev_r <= counterValue;
    end
  end

  assign cntMoved = (counterValue != cntPrev_r);
  // R04 max to zero
  // R05 match clear not detected; only max to zero sets wrap
  assign cntWrap  = (cntPrev_r == CNT_MAX) && (counterValue == CNT_ZERO);
  assign eqA      = cntMoved && (counterValue == matchA_r);
  assign eqB      = cntMoved && (counterValue == matchB_r);
  assign eqC      = cntMoved && (counterValue == matchC_r);
  assign eqD      = cntMoved && (counterValue == matchD_r);

  // R06 capture edges A/B
  // R08 compare match A
  assign setVec.a    = captureMode_r ? pinEdgeHit[0] : eqA;
  // R09 compare match B
  assign setVec.b    = captureMode_r ? pinEdgeHit[1] : eqB;
  // R07 capture edges C/D
  // R10 compare match C/D
  assign setVec.c    = captureMode_r ? pinEdgeHit[2] : eqC;
  assign setVec.d    = captureMode_r ? pinEdgeHit[3] : eqD;
  assign setVec.wrap = cntWrap;

  // R02 bit placement
  // R11 ones ignored
  // R03 reset to zero; gate-off case left to software
  genvar gf;
  generate
    for (gf = 0; gf < NUM_FLAG; gf++) begin : g_flag
      tcf_flag_cell u_cell (
        .clk       (clk),
        .rst       (rst),
        .setEvent  (setVec[gf]),
        .readDone  (flagRead),
        .readBit   (prdata_r[gf]),
        .writeDone (flagWrite),
        .writeBit  (pwdata[gf]),
        .flag_r    (flagState[gf])
      );
    end
  endgenerate

  // Interrupt status, write one to clear; a fresh event wins over the clear
  always_comb begin
    irqStat_nxt = irqStat_r;
    if (wrDone && selIrqStat) begin
      irqStat_nxt = irqStat_r & ~pwdata[NUM_FLAG-1:0];
    end
    // R17 set wins
    irqStat_nxt = irqStat_nxt | setVec;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_r  <= REG8_RESET[NUM_FLAG-1:0];
      irq_r      <= 1'b0;
      eventFlags <= REG8_RESET[NUM_FLAG-1:0];
    end else begin
      irqStat_r  <= irqStat_nxt;
      irq_r      <= |(irqStat_nxt & irqMask_r);
      eventFlags <= flagState;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

endmodule // tcf_status_flags

`default_nettype wire

// [tcf_status_flags_bench.sv]
// Self-checking bench of the channel-0 event flag block.
// Assumes an APB master and counter driven here on one 200 MHz clock.
`default_nettype none

module tcf_status_flags_bench
  import tcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, irq, pready, pslverr;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, q;
  logic [CNT_W-1:0]  counterValue = '0;
  logic [NUM_PIN-1:0] capturePin = '0;
  tcf_flags_t        eventFlags;
  logic              e;
  int                miscompares = 0, cmp_count = 0;

  tcf_status_flags dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counterValue(counterValue), .capturePin(capturePin),
    .eventFlags(eventFlags), .irq(irq));

  initial forever #2.5 clk = ~clk;

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      miscompares++;
    end
  endtask

  // Holds the request until pready is sampled; a hang is cut after 20 edges
  task automatic apb(input logic w, input logic [ADDR_W-1:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= idx << IDX_SHIFT;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      miscompares++;
      print_verdict();
    end
    @(posedge clk);
  endtask

  task automatic step(input logic [15:0] v);
    counterValue <= v;
    repeat (3) @(posedge clk);
  endtask

  task automatic clr_all;
    apb(0, IDX_FLAGS, 0);
    apb(1, IDX_FLAGS, 0);
  endtask

  task automatic t_reset;
    apb(0, IDX_FLAGS, 0);
    chk("flags", 0, q);
    chk("irq", 0, 32'(irq));
    $display("done reset");
  endtask

  task automatic t_wrap;
    step(16'hffff);
    step(16'h0000);
    apb(0, IDX_FLAGS, 0);
    chk("wrap", 32'h1f, q);
    apb(1, IDX_FLAGS, 0);
    // Flag output trails the register by one cycle
    @(posedge clk);
    chk("clear", 0, 32'(eventFlags));
    $display("done wrap");
  endtask

  task automatic t_cmp;
    for (int i = 0; i < 4; i++) apb(1, 24'(IDX_MATCH_A + i), 32'h10 * (i + 1));
    for (int i = 0; i < 4; i++) begin
      step(16'(16'h10 * (i + 1)));
      chk("match", (32'h2 << i) - 1, 32'(eventFlags));
    end
    $display("done compare");
  endtask

  task automatic t_wone;
    apb(0, IDX_FLAGS, 0);
    apb(1, IDX_FLAGS, 32'h1e);
    @(posedge clk);
    chk("w1", 32'h0e, 32'(eventFlags));
    clr_all();
    apb(0, IDX_FLAGS, 0);
    step(16'h10);
    apb(1, IDX_FLAGS, 0);
    chk("late", 32'h01, 32'(eventFlags));
    $display("done write rules");
  endtask

  task automatic t_cap;
    clr_all();
    apb(1, IDX_MODE, 1);
    apb(1, IDX_EDGE, 32'he4);
    capturePin <= 4'hf;
    repeat (8) @(posedge clk);
    chk("rise", 32'h05, 32'(eventFlags));
    capturePin <= 4'h0;
    repeat (8) @(posedge clk);
    chk("fall", 32'h07, 32'(eventFlags));
    apb(1, IDX_MODE, 0);
    $display("done capture");
  endtask

  task automatic t_irq;
    apb(1, IDX_IRQ_STAT, 32'h1f);
    apb(1, IDX_IRQ_MASK, 1);
    step(16'h20);
    chk("masked", 0, 32'(irq));
    step(16'h10);
    chk("raised", 1, 32'(irq));
    apb(1, IDX_IRQ_STAT, 1);
    repeat (2) @(posedge clk);
    chk("cleared", 0, 32'(irq));
    apb(0, 24'h0f0400, 0);
    chk("err", 1, 32'(e));
    chk("errdata", 0, q);
    apb(0, IDX_FLAGS, 0);
    apb(1, IDX_FLAGS, 0);
    step(16'h20);
    apb(0, IDX_FLAGS, 0);
    apb(1, IDX_FLAGS, 32'h1d);
    @(posedge clk);
    chk("swclear", 0, 32'(eventFlags));
    $display("done irq");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_reset();
    t_wrap();
    t_cmp();
    t_wone();
    t_cap();
    t_irq();
    print_verdict();
  end
endmodule // tcf_status_flags_bench

`default_nettype wire

// [tcf_status_flags_checker.sv]
// Concurrent checks on the ports of the channel-0 event flag block.
// Assumes eventFlags trails the flag register by one cycle.
`default_nettype none

module tcf_status_flags_checker
  import tcf_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [CNT_W-1:0]  counterValue,
  input wire logic [NUM_PIN-1:0] capturePin,
  input wire tcf_flags_t        eventFlags,
  input wire logic              irq
);
  localparam logic [ADDR_W-1:0] FLAG_ADDR = IDX_FLAGS << IDX_SHIFT;
  localparam logic [ADDR_W-1:0] STAT_ADDR = IDX_IRQ_STAT << IDX_SHIFT;
  localparam logic [ADDR_W-1:0] MASK_ADDR = IDX_IRQ_MASK << IDX_SHIFT;
  wire logic       done    = psel && penable && pready;
  wire logic       wrFlags = done && pwrite && paddr == FLAG_ADDR;
  wire logic       rdFlags = done && !pwrite && paddr == FLAG_ADDR;
  wire logic       wrStat  = done && pwrite && paddr == STAT_ADDR;
  wire logic       wrMask  = done && pwrite && paddr == MASK_ADDR;
  wire logic [4:0] wrBits  = pwdata[4:0];
  logic [4:0]      armedMask_r;
  logic [4:0]      prevFlags_r;
  wire logic [4:0] fallMask = prevFlags_r & ~eventFlags;

  // Only a read that returned one may arm a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      armedMask_r <= '0;
      prevFlags_r <= '0;
    end else begin
      prevFlags_r <= eventFlags;
      if (rdFlags) armedMask_r <= prdata[4:0];
      else if (wrFlags) armedMask_r <= '0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  access_two_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("access phase length wrong");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  refuse_read_a: assert property (done && pslverr && !pwrite |-> prdata == '0)
    else $error("refused read returned data");
  high_bits_a: assert property (rdFlags |-> prdata[31:5] == '0)
    else $error("flag read upper bits set");
  reset_clear_a: assert property ($fell(rst) |-> eventFlags == '0 && !irq)
    else $error("flags not zero after reset");
  wrap_sets_a: assert property ($past(counterValue) == CNT_MAX && counterValue == CNT_ZERO
    |-> ##[1:3] eventFlags.wrap)
    else $error("wrap flag not set");
  fall_write_a: assert property (|fallMask |-> $past(wrFlags, 2) &&
    (fallMask & $past(wrBits, 2)) == '0)
    else $error("flag fell without zero write");
  fall_read_a: assert property (|fallMask |-> (fallMask & ~$past(armedMask_r, 2)) == '0)
    else $error("flag fell without earlier one read");
  // Status clear drops irq one cycle after the write, a mask change two
  irq_fall_a: assert property ($fell(irq) |-> $past(wrStat) || $past(wrMask, 2))
    else $error("irq fell without status or mask write");
endmodule // tcf_status_flags_checker

bind tcf_status_flags tcf_status_flags_checker chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .counterValue(counterValue), .capturePin(capturePin), .eventFlags(eventFlags), .irq(irq));

`default_nettype wire
